// *** npe_engine.sv ***
// Sector check-code engine between the on-chip buffer memory and the page buffer.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Detect two-bit errors, correct one, main and spare.
// - Program: 24-bit code per sector main data.
// - Program: 10-bit code over spare words two, three.
// - Load: regenerate codes, compare with stored codes.
// - Single erroneous data bit is flipped in buffer.
// - Status updated automatically at end of load.
// - Classes: none, correctable single, uncorrectable double.
// - Load copies stored code, not regenerated code.
// - Boot loads get identical checking and correction.
// - Bypass: no codes generated, no error position.
// - Bypass program leaves stored code un-updated.
// - Bypass load: no check, status invalid, code copied.
// - Bypass selected by configuration bit nine.
module npe_engine (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic [15:0] sys_cfg1,
   input  wire logic        prg_start,
   input  wire logic        ld_start,
   input  wire logic        boot_start,
   input  wire logic        src_valid,
   input  wire logic [15:0] src_data,
   output logic             src_ready,
   output logic             busy,
   output logic             pb_we_q,
   output logic [8:0]       pb_addr_q,
   output logic [15:0]      pb_data_q,
   output logic             buf_we_q,
   output logic             buf_re_q,
   output logic [8:0]       buf_addr_q,
   output logic [15:0]      buf_wdata_q,
   input  wire logic [15:0] buf_rdata,
   output logic [1:0]       ecc_class_q,
   output logic             ecc_valid_q,
   output logic [11:0]      err_pos_main_q,
   output logic [4:0]       err_pos_spr_q,
   output logic             prg_done_q,
   output logic             ld_done_q
);

   // Folds one word into a pair-parity code; word address bits index the upper pairs.
   function automatic logic [23:0] ecc_acc(input logic [23:0] c, input logic [15:0] d,
                                           input logic [7:0] w);
      logic [23:0] r;
      logic        par;
      r   = c;
      par = ^d;
      for (int i = 0; i < npe_pkg::BIT_ADDR_W; i++) begin
         for (int b = 0; b < 16; b++) begin
            if (((b >> i) & 1) == 1) begin
               r[2*i+1] = r[2*i+1] ^ d[b];
            end else begin
               r[2*i] = r[2*i] ^ d[b];
            end
         end
      end
      for (int i = npe_pkg::BIT_ADDR_W; i < npe_pkg::NPAIR_MAIN; i++) begin
         if (w[i-npe_pkg::BIT_ADDR_W]) begin
            r[2*i+1] = r[2*i+1] ^ par;
         end else begin
            r[2*i] = r[2*i] ^ par;
         end
      end
      return r;
   endfunction

   // True when every used pair differs, which marks one flipped data bit.
   function automatic logic fix_ok(input logic [23:0] syn, input int n);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < npe_pkg::NPAIR_MAIN; i++) begin
         if (i < n) begin
            ok = ok & (syn[2*i] ^ syn[2*i+1]);
         end else begin
            ok = ok & ~(syn[2*i] | syn[2*i+1]);
         end
      end
      return ok;
   endfunction

   // Sorts a syndrome into one of the three error classes.
   function automatic logic [1:0] classify(input logic [23:0] syn, input int n);
      logic [1:0] k;
      if (syn == 24'h000000) begin
         k = npe_pkg::CLS_NONE;
      end else if (fix_ok(syn, n)) begin
         k = npe_pkg::CLS_CORR;
      end else if ((syn & (syn - 24'h000001)) == 24'h000000) begin
         k = npe_pkg::CLS_CORR;  // A single flipped bit inside the stored code.
      end else begin
         k = npe_pkg::CLS_UNC;
      end
      return k;
   endfunction

   // Bit position taken from the odd half of each pair.
   function automatic logic [11:0] pos_of(input logic [23:0] syn);
      logic [11:0] p;
      for (int i = 0; i < npe_pkg::NPAIR_MAIN; i++) begin
         p[i] = syn[2*i+1];
      end
      return p;
   endfunction

   npe_pkg::npe_state_t st_q, st_d;
   logic [8:0]  idx_q, idx_d;
   logic        byp_q, byp_d;
   logic [23:0] mcode_q, mcode_d;
   logic [9:0]  scode_q, scode_d;
   logic [23:0] smc_q, smc_d;
   logic [9:0]  ssc_q, ssc_d;
   logic        fixm_q, fixm_d;
   logic        fixs_q, fixs_d;
   logic [1:0]  cls_d, cls_m, cls_s;
   logic        vld_d;
   logic [11:0] posm_d;
   logic [4:0]  poss_d;
   logic        pb_we_d, buf_we_d, buf_re_d, prg_done_d, ld_done_d;
   logic [8:0]  pb_addr_d, buf_addr_d;
   logic [15:0] pb_data_d, buf_wdata_d;

   logic        accept;
   logic        is_main;
   logic        is_spr;
   logic [23:0] macc;
   logic [23:0] sacc;
   logic [23:0] msyn;
   logic [23:0] ssyn;
   logic [11:0] mpos;
   logic [11:0] spos;
   logic [15:0] mmask;
   logic [15:0] smask;
   logic [8:0]  spr_addr;

   // Word index step, held at the index width so the increment keeps nine bits.
   localparam logic [8:0] IDX_STEP_W = npe_pkg::IDX_STEP;

   // Stream handshake and per-word decode shared by program and load.
   assign busy      = (st_q != npe_pkg::ST_IDLE);
   assign src_ready = clk_en && (st_q == npe_pkg::ST_PRG || st_q == npe_pkg::ST_LOAD);
   assign accept    = src_valid && src_ready;
   assign is_main   = (idx_q < npe_pkg::MAIN_WORDS);
   assign is_spr    = (idx_q == npe_pkg::W_SPR_A) || (idx_q == npe_pkg::W_SPR_B);
   assign macc      = ecc_acc(mcode_q, src_data, idx_q[7:0]);
   assign sacc      = ecc_acc({14'h0000, scode_q}, src_data,
                              {7'h00, idx_q == npe_pkg::W_SPR_B});

   // Syndromes of regenerated against stored codes, and the flip masks.
   assign msyn     = mcode_q ^ smc_q;
   assign ssyn     = {14'h0000, scode_q ^ ssc_q};
   assign mpos     = pos_of(msyn);
   assign spos     = pos_of(ssyn);
   assign cls_m    = classify(msyn, npe_pkg::NPAIR_MAIN);
   assign cls_s    = classify(ssyn, npe_pkg::NPAIR_SPR);
   assign mmask    = 16'h0001 << err_pos_main_q[3:0];
   assign smask    = 16'h0001 << err_pos_spr_q[3:0];
   assign spr_addr = npe_pkg::W_SPR_A + {8'h00, err_pos_spr_q[4]};

   // Next-state logic of the sequencer, code accumulators and output strobes.
   always_comb begin
      st_d        = st_q;
      idx_d       = idx_q;
      byp_d       = byp_q;
      mcode_d     = mcode_q;
      scode_d     = scode_q;
      smc_d       = smc_q;
      ssc_d       = ssc_q;
      fixm_d      = fixm_q;
      fixs_d      = fixs_q;
      cls_d       = ecc_class_q;
      vld_d       = ecc_valid_q;
      posm_d      = err_pos_main_q;
      poss_d      = err_pos_spr_q;
      pb_we_d     = 1'b0;
      pb_addr_d   = pb_addr_q;
      pb_data_d   = pb_data_q;
      buf_we_d    = 1'b0;
      buf_re_d    = 1'b0;
      buf_addr_d  = buf_addr_q;
      buf_wdata_d = buf_wdata_q;
      prg_done_d  = 1'b0;
      ld_done_d   = 1'b0;
      unique case (st_q)
         npe_pkg::ST_IDLE: begin
            idx_d   = 9'h000;
            mcode_d = 24'h000000;
            scode_d = 10'h000;
            byp_d   = sys_cfg1[npe_pkg::CFG1_BYPASS_BIT];
            if (prg_start) begin
               st_d = npe_pkg::ST_PRG;
            end else if (ld_start || boot_start) begin
               st_d = npe_pkg::ST_LOAD;
            end
         end
         npe_pkg::ST_PRG: begin
            if (accept) begin
               idx_d     = idx_q + IDX_STEP_W;
               pb_we_d   = 1'b1;
               pb_addr_d = idx_q;
               pb_data_d = src_data;
               if (!byp_q) begin
                  if (is_main) begin
                     mcode_d = macc;
                  end
                  if (is_spr) begin
                     scode_d = sacc[9:0];
                  end
                  if (idx_q == npe_pkg::W_MCODE_LO) begin
                     pb_data_d = mcode_q[15:0];
                  end else if (idx_q == npe_pkg::W_MCODE_HI) begin
                     pb_data_d = {npe_pkg::MCODE_HI_FILL, mcode_q[23:16]};
                  end else if (idx_q == npe_pkg::W_SCODE) begin
                     pb_data_d = {npe_pkg::SCODE_FILL, scode_q};
                  end
               end else if (idx_q == npe_pkg::W_MCODE_LO || idx_q == npe_pkg::W_MCODE_HI
                            || idx_q == npe_pkg::W_SCODE) begin
                  pb_we_d = 1'b0;
               end
               if (idx_q == npe_pkg::W_LAST) begin
                  st_d       = npe_pkg::ST_IDLE;
                  prg_done_d = 1'b1;
               end
            end
         end
         npe_pkg::ST_LOAD: begin
            if (accept) begin
               idx_d       = idx_q + IDX_STEP_W;
               buf_we_d    = 1'b1;
               buf_addr_d  = idx_q;
               buf_wdata_d = src_data;
               if (!byp_q && is_main) begin
                  mcode_d = macc;
               end
               if (!byp_q && is_spr) begin
                  scode_d = sacc[9:0];
               end
               if (idx_q == npe_pkg::W_MCODE_LO) begin
                  smc_d[15:0] = src_data;
               end
               if (idx_q == npe_pkg::W_MCODE_HI) begin
                  smc_d[23:16] = src_data[7:0];
               end
               if (idx_q == npe_pkg::W_SCODE) begin
                  ssc_d = src_data[9:0];
               end
               if (idx_q == npe_pkg::W_LAST) begin
                  st_d = npe_pkg::ST_CHECK;
               end
            end
         end
         npe_pkg::ST_CHECK: begin
            if (byp_q) begin
               vld_d     = 1'b0;
               cls_d     = npe_pkg::CLS_NONE;
               posm_d    = 12'h000;
               poss_d    = 5'h00;
               st_d      = npe_pkg::ST_IDLE;
               ld_done_d = 1'b1;
            end else begin
               vld_d  = 1'b1;
               cls_d  = (cls_m > cls_s) ? cls_m : cls_s;
               fixm_d = fix_ok(msyn, npe_pkg::NPAIR_MAIN);
               fixs_d = fix_ok(ssyn, npe_pkg::NPAIR_SPR);
               posm_d = fixm_d ? mpos : 12'h000;
               poss_d = fixs_d ? spos[4:0] : 5'h00;
               if (fixm_d) begin
                  st_d       = npe_pkg::ST_FXM_RD;
                  buf_re_d   = 1'b1;
                  buf_addr_d = {1'b0, mpos[11:4]};
               end else if (fixs_d) begin
                  st_d       = npe_pkg::ST_FXS_RD;
                  buf_re_d   = 1'b1;
                  buf_addr_d = npe_pkg::W_SPR_A + {8'h00, spos[4]};
               end else begin
                  st_d      = npe_pkg::ST_IDLE;
                  ld_done_d = 1'b1;
               end
            end
         end
         npe_pkg::ST_FXM_RD: begin
            buf_wdata_d = buf_rdata ^ mmask;
            buf_we_d    = 1'b1;
            fixm_d      = 1'b0;
            st_d        = npe_pkg::ST_FXM_WR;
         end
         npe_pkg::ST_FXM_WR: begin
            if (fixs_q) begin
               st_d       = npe_pkg::ST_FXS_RD;
               buf_re_d   = 1'b1;
               buf_addr_d = spr_addr;
            end else begin
               st_d      = npe_pkg::ST_IDLE;
               ld_done_d = 1'b1;
            end
         end
         npe_pkg::ST_FXS_RD: begin
            buf_wdata_d = buf_rdata ^ smask;
            buf_we_d    = 1'b1;
            fixs_d      = 1'b0;
            st_d        = npe_pkg::ST_FXS_WR;
         end
         npe_pkg::ST_FXS_WR: begin
            st_d      = npe_pkg::ST_IDLE;
            ld_done_d = 1'b1;
         end
      endcase
   end

   // State registers; a low clock enable freezes everything except the synchronous reset.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_q           <= npe_pkg::ST_IDLE;
         idx_q          <= 9'h000;
         byp_q          <= 1'b0;
         mcode_q        <= 24'h000000;
         scode_q        <= 10'h000;
         smc_q          <= 24'h000000;
         ssc_q          <= 10'h000;
         fixm_q         <= 1'b0;
         fixs_q         <= 1'b0;
         ecc_class_q    <= npe_pkg::CLS_NONE;
         ecc_valid_q    <= 1'b0;
         err_pos_main_q <= 12'h000;
         err_pos_spr_q  <= 5'h00;
         pb_we_q        <= 1'b0;
         pb_addr_q      <= 9'h000;
         pb_data_q      <= 16'h0000;
         buf_we_q       <= 1'b0;
         buf_re_q       <= 1'b0;
         buf_addr_q     <= 9'h000;
         buf_wdata_q    <= 16'h0000;
         prg_done_q     <= 1'b0;
         ld_done_q      <= 1'b0;
      end else if (clk_en) begin
         st_q           <= st_d;
         idx_q          <= idx_d;
         byp_q          <= byp_d;
         mcode_q        <= mcode_d;
         scode_q        <= scode_d;
         smc_q          <= smc_d;
         ssc_q          <= ssc_d;
         fixm_q         <= fixm_d;
         fixs_q         <= fixs_d;
         ecc_class_q    <= cls_d;
         ecc_valid_q    <= vld_d;
         err_pos_main_q <= posm_d;
         err_pos_spr_q  <= poss_d;
         pb_we_q        <= pb_we_d;
         pb_addr_q      <= pb_addr_d;
         pb_data_q      <= pb_data_d;
         buf_we_q       <= buf_we_d;
         buf_re_q       <= buf_re_d;
         buf_addr_q     <= buf_addr_d;
         buf_wdata_q    <= buf_wdata_d;
         prg_done_q     <= prg_done_d;
         ld_done_q      <= ld_done_d;
      end
   end

   // Checks on the generated codes, the copy paths and the correction order.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence seq_fix_main;
      (st_q == npe_pkg::ST_FXM_RD) && clk_en ##1 buf_we_q;
   endsequence

   chk_main_code_out: assert property (accept && st_q == npe_pkg::ST_PRG && !byp_q
      && idx_q == npe_pkg::W_MCODE_LO |=> pb_we_q && pb_data_q == $past(mcode_q[15:0]))
      else $error("Main code word not written during program.");
   chk_spare_code_out: assert property (accept && st_q == npe_pkg::ST_PRG && !byp_q
      && idx_q == npe_pkg::W_SCODE |=> pb_data_q[9:0] == $past(scode_q))
      else $error("Spare code word not written during program.");
   chk_bypass_keep: assert property (accept && st_q == npe_pkg::ST_PRG && byp_q
      && (idx_q == npe_pkg::W_MCODE_LO || idx_q == npe_pkg::W_SCODE) |=> !pb_we_q)
      else $error("Stored code overwritten in bypass program.");
   chk_load_copy: assert property (accept && st_q == npe_pkg::ST_LOAD
      |=> buf_we_q && buf_wdata_q == $past(src_data) && buf_addr_q == $past(idx_q))
      else $error("Loaded word not copied unchanged to the buffer.");
   chk_fix_flip: assert property (seq_fix_main
      |-> buf_wdata_q == ($past(buf_rdata) ^ $past(mmask)))
      else $error("Corrected word does not flip exactly the error bit.");
   chk_done_after_fix: assert property (ld_done_q |-> !fixm_q && !fixs_q)
      else $error("Load reported done before correction finished.");
   chk_status_update: assert property (st_q == npe_pkg::ST_CHECK && clk_en && !byp_q
      |=> ecc_valid_q && ld_done_q || st_q != npe_pkg::ST_IDLE)
      else $error("Status not updated at end of load.");
   chk_bypass_invalid: assert property (ld_done_q && byp_q
      |-> !ecc_valid_q && err_pos_main_q == 12'h000 && mcode_q == 24'h000000)
      else $error("Bypass load left valid status or generated code.");
   chk_uncorr_nofix: assert property (ecc_class_q == npe_pkg::CLS_UNC && ld_done_q
      |-> $past(st_q) == npe_pkg::ST_CHECK)
      else $error("Uncorrectable error led to a correction write.");

endmodule

`default_nettype wire

// *** npe_pkg.sv ***
// Shared constants and types for the NAND page check-code engine.
`default_nettype none
package npe_pkg;

   // Word layout of one sector as it streams through the engine.
   localparam logic [8:0]  MAIN_WORDS     = 9'h100;  // Main data words 0..255.
   localparam logic [8:0]  W_SPR_A        = 9'h101;  // Second spare word, protected.
   localparam logic [8:0]  W_SPR_B        = 9'h102;  // Third spare word, protected.
   localparam logic [8:0]  W_MCODE_LO     = 9'h104;  // Main code bits 15:0.
   localparam logic [8:0]  W_MCODE_HI     = 9'h105;  // Main code bits 23:16 in low byte.
   localparam logic [8:0]  W_SCODE        = 9'h106;  // Spare code bits 9:0.
   localparam logic [8:0]  W_LAST         = 9'h107;  // Last word of the sector.
   localparam logic [8:0]  IDX_STEP       = 9'h001;

   // Fill patterns for unused bits of the code words.
   localparam logic [7:0]  MCODE_HI_FILL  = 8'hff;
   localparam logic [5:0]  SCODE_FILL     = 6'h3f;

   // Code sizes, as pairs of even and odd parities.
   localparam int          NPAIR_MAIN     = 12;
   localparam int          NPAIR_SPR      = 5;
   localparam int          MCODE_W        = 24;
   localparam int          SCODE_W        = 10;
   localparam int          BIT_ADDR_W     = 4;

   // Configuration word bit that selects bypass.
   localparam int          CFG1_BYPASS_BIT = 9;

   // Error class reported after a load, ordered by severity.
   localparam logic [1:0]  CLS_NONE       = 2'h0;
   localparam logic [1:0]  CLS_CORR       = 2'h1;
   localparam logic [1:0]  CLS_UNC        = 2'h2;

   // Sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_PRG    = 3'b001,
      ST_LOAD   = 3'b010,
      ST_CHECK  = 3'b011,
      ST_FXM_RD = 3'b100,
      ST_FXM_WR = 3'b101,
      ST_FXS_RD = 3'b110,
      ST_FXS_WR = 3'b111
   } npe_state_t;

endpackage
`default_nettype wire

// *** npe_mem_model.sv ***
// Behavioural page buffer and on-chip buffer memory facing the engine.
`timescale 1ns/1ps
`default_nettype none
module npe_mem_model (
   input  wire logic        mclk,
   input  wire logic        pb_we,
   input  wire logic [8:0]  pb_addr,
   input  wire logic [15:0] pb_data,
   input  wire logic        buf_we,
   input  wire logic        buf_re,
   input  wire logic [8:0]  buf_addr,
   input  wire logic [15:0] buf_wdata,
   output logic      [15:0] buf_rdata
);
   logic [15:0] pb_mem  [0:263];
   logic [15:0] buf_mem [0:263];
   // Both memories take a word on each rising edge that carries a write strobe.
   always @(posedge mclk) begin
      if (pb_we) pb_mem[pb_addr] <= pb_data;
      if (buf_we) buf_mem[buf_addr] <= buf_wdata;
   end
   // Outside a read strobe the lines show the inverse, so a stale sample is caught.
   assign buf_rdata = buf_re ? buf_mem[buf_addr] : ~buf_mem[buf_addr];
endmodule
`default_nettype wire

// *** test_nand_page_ecc_engine.sv ***
// Self-checking testbench for the sector check-code engine.
`timescale 1ns/1ps
`default_nettype none
module test_nand_page_ecc_engine;
   logic        mclk, rst_n, clk_en, prg_start, ld_start, boot_start, src_valid, src_ready;
   logic        busy, pb_we_q, buf_we_q, buf_re_q, ecc_valid_q, prg_done_q, ld_done_q;
   logic [15:0] sys_cfg1, src_data, pb_data_q, buf_wdata_q, buf_rdata;
   logic [8:0]  pb_addr_q, buf_addr_q;
   logic [1:0]  ecc_class_q;
   logic [11:0] err_pos_main_q;
   logic [4:0]  err_pos_spr_q;
   logic [15:0] sec [0:263];
   int          error_cnt, n_checks;

   npe_engine DUT (.mclk, .rst_n, .clk_en, .sys_cfg1, .prg_start, .ld_start, .boot_start,
      .src_valid, .src_data, .src_ready, .busy, .pb_we_q, .pb_addr_q, .pb_data_q, .buf_we_q,
      .buf_re_q, .buf_addr_q, .buf_wdata_q, .buf_rdata, .ecc_class_q, .ecc_valid_q,
      .err_pos_main_q, .err_pos_spr_q, .prg_done_q, .ld_done_q);
   npe_mem_model u_mem (.mclk, .pb_we(pb_we_q), .pb_addr(pb_addr_q), .pb_data(pb_data_q),
      .buf_we(buf_we_q), .buf_re(buf_re_q), .buf_addr(buf_addr_q), .buf_wdata(buf_wdata_q),
      .buf_rdata);

   // Free-running clock with a 4 ns period.
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Records one comparison and reports a mismatch at once.
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Even and odd parity pairs over a word range, na address bits per data bit.
   function automatic logic [23:0] calc(input int first, input int last, input int na);
      logic [23:0] c;
      logic [11:0] a;
      c = '0;
      for (int w = first; w <= last; w++)
         for (int b = 0; b < 16; b++) begin
            a = (na == 12) ? {w[7:0], b[3:0]} : {7'h00, w == 258, b[3:0]};
            for (int i = 0; i < na; i++)
               if (sec[w][b]) c[2*i+a[i]] = ~c[2*i+a[i]];
         end
      return c;
   endfunction

   // Fills a sector with a pattern and the code words a correct program stores.
   task automatic build(input logic [15:0] k);
      logic [23:0] m;
      logic [23:0] s;
      for (int i = 0; i < 264; i++) sec[i] = 16'(i * 977) ^ k;
      sec[256] = 16'hffff;
      m = calc(0, 255, 12);
      s = calc(257, 258, 5);
      sec[260] = m[15:0];
      sec[261] = {npe_pkg::MCODE_HI_FILL, m[23:16]};
      sec[262] = {npe_pkg::SCODE_FILL, s[9:0]};
   endtask

   // Starts one operation, streams the sector with a short stall, waits for done.
   task automatic run_op(input int kind);
      int   idx;
      int   t;
      logic rdy;
      logic done;
      prg_start = (kind == 0);
      ld_start = (kind == 1);
      boot_start = (kind == 2);
      @(negedge mclk);
      {prg_start, ld_start, boot_start} = 3'h0;
      idx = 0;
      t = 0;
      done = 1'b0;
      while (idx < 264 && t < 2000) begin
         clk_en = !(t >= 40 && t < 43);
         src_valid = 1'b1;
         src_data = sec[idx];
         #1 rdy = src_ready;
         @(negedge mclk);
         t++;
         if (rdy === 1'b1) idx++;
      end
      {src_valid, clk_en} = 2'h1;
      for (t = 0; t < 20 && !done; t++) begin
         done = ((kind == 0) ? prg_done_q : ld_done_q) === 1'b1;
         if (!done) @(negedge mclk);
      end
      chk(24'(done), 24'h1);
      @(negedge mclk);
   endtask

   // Programs a sector with blanks in the code slots and checks the page buffer.
   task automatic t_prg(input logic byp);
      logic [15:0] exp [0:2];
      build(16'h1234 ^ {15'h0, byp});
      for (int i = 0; i < 3; i++) begin
         exp[i] = byp ? 16'h5a5a : sec[260+i];
         sec[260+i] = 16'h0000;
         u_mem.pb_mem[260+i] = 16'h5a5a;
      end
      sys_cfg1 = 16'(byp) << npe_pkg::CFG1_BYPASS_BIT;
      run_op(0);
      chk(24'(u_mem.pb_mem[255]), 24'(sec[255]));
      for (int i = 0; i < 3; i++) chk(24'(u_mem.pb_mem[260+i]), 24'(exp[i]));
      $display("program test done, bypass %0d", byp);
   endtask

   // Loads a sector with up to two flipped bits and checks buffer and status.
   task automatic t_ld(input int kind, input logic byp, input int w0, input int b0,
                       input int w1, input logic [1:0] cls);
      logic [15:0] good [0:263];
      int          nbad;
      logic [11:0] pm;
      logic [4:0]  ps;
      build(16'h0f0f ^ 16'(w0));
      good = sec;
      sys_cfg1 = 16'(byp) << npe_pkg::CFG1_BYPASS_BIT;
      if (w0 >= 0) sec[w0][b0] = ~sec[w0][b0];
      if (w1 >= 0) sec[w1][0] = ~sec[w1][0];
      run_op(kind);
      nbad = 0;
      for (int i = 0; i < 264; i++)
         nbad += int'(u_mem.buf_mem[i] !== ((cls == npe_pkg::CLS_CORR) ? good[i] : sec[i]));
      chk(24'(nbad), 24'h0);
      chk(24'(ecc_valid_q), 24'(!byp));
      if (!byp) chk(24'(ecc_class_q), 24'(cls));
      pm = (cls == npe_pkg::CLS_CORR && w0 < 256) ? {w0[7:0], b0[3:0]} : 12'h000;
      ps = (cls == npe_pkg::CLS_CORR && w0 > 255) ? {w0 == 258, b0[3:0]} : 5'h00;
      chk(24'({err_pos_main_q, err_pos_spr_q}), 24'({pm, ps}));
      $display("load test done, kind %0d bypass %0d", kind, byp);
   endtask

   // Cuts a hang short; the whole run needs under 2,500 cycles.
   initial begin
      #40000;
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end

   // Resets the engine, then runs every scenario in turn.
   initial begin
      {rst_n, clk_en, prg_start, ld_start, boot_start, src_valid} = 6'h10;
      sys_cfg1 = 16'h0000;
      src_data = 16'h0000;
      error_cnt = 0;
      n_checks = 0;
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      chk(24'({ecc_class_q, ecc_valid_q, busy}), 24'h0);
      t_prg(1'b0);
      t_prg(1'b1);
      t_ld(1, 1'b0, -1, 0, -1, npe_pkg::CLS_NONE);
      t_ld(1, 1'b0, 255, 15, -1, npe_pkg::CLS_CORR);
      t_ld(2, 1'b0, 258, 11, -1, npe_pkg::CLS_CORR);
      t_ld(1, 1'b0, 3, 7, 200, npe_pkg::CLS_UNC);
      t_ld(1, 1'b1, 10, 2, -1, npe_pkg::CLS_NONE);
      print_verdict();
   end
endmodule
`default_nettype wire
